// >>> src/bmal_pkg.sv
/*
 * Package for the battery measure and alert block: register addresses,
 * field positions, reset values, timing counts and shared types.
 * Assumes a byte-wide register port driven by the serial bus front end.
 */
package bmal_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 250;
    localparam int CUR_PERIOD_MS = 88;
    localparam int VOLT_PERIOD_US = 3400;
    localparam int TEMP_PERIOD_MS = 220;
    localparam int DQ_LOW_MS = 2000;
    localparam int CUR_PERIOD_CYC = CUR_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int VOLT_PERIOD_CYC = VOLT_PERIOD_US * CLK_MHZ;
    localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int DQ_LOW_CYC = DQ_LOW_MS * 1000 * CLK_MHZ;
    localparam int CUR_AVG_N = 128;
    localparam int CUR_AVG_LOG2 = 7;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_SPECIAL = 8'h08;
    localparam logic [7:0] ADDR_VOLT_MSB = 8'h0c;
    localparam logic [7:0] ADDR_VOLT_LSB = 8'h0d;
    localparam logic [7:0] ADDR_CUR_MSB = 8'h0e;
    localparam logic [7:0] ADDR_CUR_LSB = 8'h0f;
    localparam logic [7:0] ADDR_ACC_MSB = 8'h10;
    localparam logic [7:0] ADDR_ACC_LSB = 8'h11;
    localparam logic [7:0] ADDR_TEMP_MSB = 8'h18;
    localparam logic [7:0] ADDR_TEMP_LSB = 8'h19;
    localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h33;
    localparam logic [7:0] ADDR_ACC_HI_MSB = 8'h80;
    localparam logic [7:0] ADDR_ACC_HI_LSB = 8'h81;
    localparam logic [7:0] ADDR_ACC_LO_MSB = 8'h82;
    localparam logic [7:0] ADDR_ACC_LO_LSB = 8'h83;
    localparam logic [7:0] ADDR_TEMP_HI = 8'h84;
    localparam logic [7:0] ADDR_TEMP_LO = 8'h85;

    // ==========================================================
    // Field positions and reset values
    localparam int STAT_IE_BIT = 2;
    localparam int STAT_PACK_SLEEP_ALLOW_BIT = 5;
    localparam int SPEC_PIO_BIT = 6;
    localparam int SPEC_PS_BIT = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] OFFSET_TRIM_RST = 8'h00;
    localparam logic [15:0] THRESH_RST = 16'h0000;
    localparam logic [7:0] TEMP_TH_RST = 8'h00;
    localparam logic [15:0] VOLT_MAX_CODE = 16'h7fe0;
    localparam logic signed [15:0] CUR_MAX = 16'sh7fff;
    localparam logic signed [15:0] CUR_MIN = -16'sh7fff - 16'sh0001;

    // ==========================================================
    // Shared types
    typedef enum logic {BMAL_ACTIVE, BMAL_SLEEP} bmal_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bmal_req_s;

    typedef struct packed {
        logic valid;
        logic signed [11:0] value;
    } bmal_sample_s;

    // Saturate a wide signed value into a 16-bit result
    function automatic logic [15:0] bmal_sat16(input logic signed [31:0] v);
        if (v > 32'sd32767) begin
            return 16'h7fff;
        end else if (v < -32'sd32768) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction
endpackage

// >>> src/bmal_period.sv
/*
 * Free-running interval timer: one pulse every PERIOD cycles.
 * Assumes the enable stays high in active mode; a low holds it cleared.
 */
`timescale 1ns/1ps
`default_nettype none
module bmal_period import bmal_pkg::*; #(
    parameter int PERIOD = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    logic [31:0] cnt_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 32'h0000_0000;
        end else if (!run || cnt_q == 32'(PERIOD - 1)) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    assign tick = run && (cnt_q == 32'(PERIOD - 1));

    chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tick |=> !tick)
        else $error("interval tick repeated");
endmodule
`default_nettype wire

// >>> src/bmal_cur_avg.sv
/*
 * Current averager: subtracts the offset trim from each 12-bit sense
 * sample, sums 128 of them and emits the sum over 8 (16 times the average), clamped to 16 bits.
 * Assumes samples arrive as single-cycle valid strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module bmal_cur_avg import bmal_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire bmal_sample_s sample,
    input wire logic [7:0] offset_trim,
    output logic [15:0] avg_q,
    output logic done_q
);
    logic signed [31:0] sum_q;
    logic [6:0] n_q;
    logic signed [31:0] corr;
    logic signed [31:0] total;

    // Trim applies per sample so reporting and accumulation both see it
    assign corr = 32'(sample.value) - 32'(signed'(offset_trim));
    assign total = sum_q + corr;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_q <= '0;
            n_q <= 7'h00;
            avg_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (sample.valid) begin
                n_q <= n_q + 7'h01;
                if (n_q == 7'(CUR_AVG_N - 1)) begin
                    // Sum of 128 samples scaled to a 16-bit result
                    avg_q <= bmal_sat16(total >>> (CUR_AVG_LOG2 - 4));
                    done_q <= 1'b1;
                    sum_q <= '0;
                end else begin
                    sum_q <= total;
                end
            end
        end
    end

    chk_avg_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        done_q |-> $past(n_q) == 7'h7f)
        else $error("average done without 128 samples");
endmodule
`default_nettype wire

// >>> src/bmal_top.sv
/*
 * Measurement and alert logic of a battery monitor: result registers,
 * charge accumulator, threshold alarms on the shared pin, power switch.
 * Assumes the serial bus front end presents byte reads and writes on
 * req and that analog converters deliver signed samples with strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module bmal_top import bmal_pkg::*; #(
    parameter int CUR_CYC = CUR_PERIOD_CYC,
    parameter int VOLT_CYC = VOLT_PERIOD_CYC,
    parameter int TEMP_CYC = TEMP_PERIOD_CYC,
    parameter int DQLOW_CYC = DQ_LOW_CYC,
    parameter int ACC_DIV = 4096
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire bmal_req_s req,
    output logic [7:0] rdata_q,
    input wire bmal_sample_s sense_diff_voltage,
    input wire bmal_sample_s volt_sample,
    input wire bmal_sample_s temp_sample,
    input wire logic bus_line_low,
    input wire logic sleep_req,
    input wire logic power_switch_in_n,
    input wire logic shared_io_pin_i,
    output logic shared_io_pin_o,
    output logic shared_io_pin_oe,
    output logic asleep_q,
    output logic discharge_on_q
);
    // ==========================================================
    // State
    bmal_mode_e mode_q;
    logic [7:0] status_q;
    logic pio_bit_q;
    logic ps_bit_q;
    logic [7:0] offset_trim_q;
    logic [15:0] cur_q;
    logic [15:0] volt_q;
    logic [15:0] temp_q;
    logic signed [15:0] acc_q;
    logic signed [31:0] acc_frac_q;
    logic [15:0] acc_hi_q;
    logic [15:0] acc_lo_q;
    logic [7:0] temp_hi_q;
    logic [7:0] temp_lo_q;
    logic [31:0] dq_cnt_q;
    logic dq_long_low;
    logic [7:0] latch_lsb_q;
    logic cur_tick, volt_tick, temp_tick;
    logic [15:0] cur_avg;
    logic cur_done;
    logic alarm_ie;
    logic alarm_cond;
    logic pio_release;
    logic active;

    assign active = (mode_q == BMAL_ACTIVE);
    assign alarm_ie = status_q[STAT_IE_BIT];

    // ==========================================================
    // Interval timers and current averager
    bmal_period #(.PERIOD(CUR_CYC)) u_cur_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(active),
        .tick(cur_tick)
    );
    bmal_period #(.PERIOD(VOLT_CYC)) u_volt_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(active),
        .tick(volt_tick)
    );
    bmal_period #(.PERIOD(TEMP_CYC)) u_temp_tmr (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(active),
        .tick(temp_tick)
    );
    bmal_cur_avg u_avg (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sample(sense_diff_voltage),
        .offset_trim(offset_trim_q),
        .avg_q(cur_avg),
        .done_q(cur_done)
    );

    // ==========================================================
    // Result registers; the average held until the interval tick
    logic [15:0] cur_pend_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_pend_q <= 16'h0000;
            cur_q <= 16'h0000;
        end else begin
            if (cur_done) begin
                cur_pend_q <= cur_avg;
            end
            if (cur_tick) begin
                // Sign of the sense difference carries straight through
                cur_q <= cur_pend_q;
            end
        end
    end

    // Voltage code sits in bits 14:5 with bit 15 zero, never negative
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            volt_q <= 16'h0000;
        end else if (volt_tick) begin
            if (volt_sample.value[11] || volt_sample.value[10:0] > 11'h3ff)
            begin
                volt_q <= VOLT_MAX_CODE;
            end else begin
                volt_q <= {1'b0, volt_sample.value[9:0], 5'h00};
            end
        end
    end

    // Temperature code in bits 15:5, 0.125 degree per count
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_q <= 16'h0000;
        end else if (temp_tick) begin
            temp_q <= {temp_sample.value[10:0], 5'h00};
        end
    end

    // ==========================================================
    // Charge accumulator: each averaged current is integrated into a
    // fraction; whole steps move the visible count. ACC_DIV sets the
    // ratio of current step to charge step per averaging interval.
    logic signed [31:0] frac_next;
    logic acc_wr_msb, acc_wr_lsb;
    assign acc_wr_msb = req.wr && req.addr == ADDR_ACC_MSB;
    assign acc_wr_lsb = req.wr && req.addr == ADDR_ACC_LSB;
    assign frac_next = acc_frac_q + 32'(signed'(cur_q));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= 16'sh0000;
            acc_frac_q <= '0;
        end else if (acc_wr_msb || acc_wr_lsb) begin
            // Host value becomes the new starting point
            if (acc_wr_msb) begin
                acc_q[15:8] <= req.wdata;
            end else begin
                acc_q[7:0] <= req.wdata;
            end
            acc_frac_q <= '0;
        end else if (cur_tick && active) begin
            // Charging raises, discharging lowers
            if (frac_next >= 32'(ACC_DIV)) begin
                acc_q <= bmal_sat16(32'(acc_q) + 32'sd1);
                acc_frac_q <= frac_next - 32'(ACC_DIV);
            end else if (frac_next <= -32'(ACC_DIV)) begin
                acc_q <= bmal_sat16(32'(acc_q) - 32'sd1);
                acc_frac_q <= frac_next + 32'(ACC_DIV);
            end else begin
                acc_frac_q <= frac_next;
            end
        end
    end

    // ==========================================================
    // Settings: status, offset trim, thresholds
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RST;
            offset_trim_q <= OFFSET_TRIM_RST;
            acc_hi_q <= THRESH_RST;
            acc_lo_q <= THRESH_RST;
            temp_hi_q <= TEMP_TH_RST;
            temp_lo_q <= TEMP_TH_RST;
        end else if (req.wr) begin
            case (req.addr)
                ADDR_STATUS: status_q <= req.wdata;
                ADDR_OFFSET_TRIM: offset_trim_q <= req.wdata;
                ADDR_ACC_HI_MSB: acc_hi_q[15:8] <= req.wdata;
                ADDR_ACC_HI_LSB: acc_hi_q[7:0] <= req.wdata;
                ADDR_ACC_LO_MSB: acc_lo_q[15:8] <= req.wdata;
                ADDR_ACC_LO_LSB: acc_lo_q[7:0] <= req.wdata;
                ADDR_TEMP_HI: temp_hi_q <= req.wdata;
                ADDR_TEMP_LO: temp_lo_q <= req.wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Bus line low watchdog
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_cnt_q <= 32'h0000_0000;
        end else if (!bus_line_low) begin
            dq_cnt_q <= 32'h0000_0000;
        end else if (dq_cnt_q != 32'(DQLOW_CYC)) begin
            dq_cnt_q <= dq_cnt_q + 32'h0000_0001;
        end
    end
    assign dq_long_low = (dq_cnt_q == 32'(DQLOW_CYC));

    // ==========================================================
    // Power mode and power switch
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= BMAL_ACTIVE;
            discharge_on_q <= 1'b1;
        end else begin
            case (mode_q)
                BMAL_ACTIVE: begin
                    if (sleep_req || (status_q[STAT_PACK_SLEEP_ALLOW_BIT] && dq_long_low))
                    begin
                        mode_q <= BMAL_SLEEP;
                        discharge_on_q <= 1'b0;
                    end
                end
                BMAL_SLEEP: begin
                    if (!power_switch_in_n) begin
                        mode_q <= BMAL_ACTIVE;
                        discharge_on_q <= 1'b1;
                    end
                end
                default: mode_q <= BMAL_ACTIVE;
            endcase
        end
    end
    assign asleep_q = (mode_q == BMAL_SLEEP);

    // Latch wins over the host writing 1 in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ps_bit_q <= 1'b1;
        end else if (active && !power_switch_in_n) begin
            ps_bit_q <= 1'b0;
        end else if (req.wr && req.addr == ADDR_SPECIAL) begin
            ps_bit_q <= req.wdata[SPEC_PS_BIT];
        end
    end

    // ==========================================================
    // Shared pin: open-drain output or active-low alarm
    assign pio_release = asleep_q || dq_long_low;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pio_bit_q <= 1'b1;
        end else if (pio_release) begin
            pio_bit_q <= 1'b1;
        end else if (req.wr && req.addr == ADDR_SPECIAL) begin
            pio_bit_q <= req.wdata[SPEC_PIO_BIT];
        end
    end

    // Alarm is a level, recomputed every cycle: it holds while any
    // comparison is true and releases only when all four are false
    assign alarm_cond = (acc_q > signed'(acc_hi_q))
        || (acc_q < signed'(acc_lo_q))
        || (signed'(temp_q[15:8]) > signed'(temp_hi_q))
        || (signed'(temp_q[15:8]) <= signed'(temp_lo_q));

    assign shared_io_pin_o = 1'b0;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shared_io_pin_oe <= 1'b0;
        end else if (alarm_ie) begin
            shared_io_pin_oe <= alarm_cond;
        end else begin
            shared_io_pin_oe <= !pio_bit_q && !pio_release;
        end
    end

    // ==========================================================
    // Read data; low byte snapped when the high byte is read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            latch_lsb_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_STATUS: rdata_q <= status_q;
                ADDR_SPECIAL: rdata_q <= {ps_bit_q, shared_io_pin_i, 6'h00};
                ADDR_VOLT_MSB: begin
                    rdata_q <= volt_q[15:8];
                    latch_lsb_q <= volt_q[7:0];
                end
                ADDR_CUR_MSB: begin
                    rdata_q <= cur_q[15:8];
                    latch_lsb_q <= cur_q[7:0];
                end
                ADDR_ACC_MSB: begin
                    rdata_q <= acc_q[15:8];
                    latch_lsb_q <= acc_q[7:0];
                end
                ADDR_TEMP_MSB: begin
                    rdata_q <= temp_q[15:8];
                    latch_lsb_q <= temp_q[7:0];
                end
                ADDR_VOLT_LSB, ADDR_CUR_LSB, ADDR_ACC_LSB, ADDR_TEMP_LSB:
                    rdata_q <= latch_lsb_q;
                ADDR_OFFSET_TRIM: rdata_q <= offset_trim_q;
                ADDR_ACC_HI_MSB: rdata_q <= acc_hi_q[15:8];
                ADDR_ACC_HI_LSB: rdata_q <= acc_hi_q[7:0];
                ADDR_ACC_LO_MSB: rdata_q <= acc_lo_q[15:8];
                ADDR_ACC_LO_LSB: rdata_q <= acc_lo_q[7:0];
                ADDR_TEMP_HI: rdata_q <= temp_hi_q;
                ADDR_TEMP_LO: rdata_q <= temp_lo_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Checks
    sequence s_ps_low_active;
        active && !power_switch_in_n;
    endsequence
    chk_ps_latch_zero: assert property (@(posedge sys_clk)
        disable iff (!reset_n) s_ps_low_active |=> !ps_bit_q)
        else $error("power switch low not latched");
    chk_wake_on_ps: assert property (@(posedge sys_clk) disable iff (!reset_n)
        asleep_q && !power_switch_in_n |=> !asleep_q && discharge_on_q)
        else $error("no wake on power switch");
    chk_pio_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pio_release |=> pio_bit_q && ($past(alarm_ie) || !shared_io_pin_oe))
        else $error("pin not released");
    chk_alarm_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
        alarm_ie && alarm_cond |=> shared_io_pin_oe)
        else $error("alarm not driven");
    chk_alarm_release: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        $past(alarm_ie) && !$past(alarm_cond) |-> !shared_io_pin_oe)
        else $error("alarm held without cause");
    chk_gpio_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !alarm_ie && !pio_bit_q && !pio_release |=> shared_io_pin_oe)
        else $error("pin bit 0 not driving");
    chk_gpio_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !alarm_ie && pio_bit_q |=> !shared_io_pin_oe)
        else $error("pin driven while released");
    chk_acc_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        acc_wr_msb |=> acc_q[15:8] == $past(req.wdata))
        else $error("accumulator write lost");
    chk_volt_clamp: assert property (@(posedge sys_clk) disable iff (!reset_n)
        volt_tick && volt_sample.value[11] |=> volt_q == VOLT_MAX_CODE)
        else $error("voltage not clamped");
    chk_cur_update: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cur_tick |=> cur_q == $past(cur_pend_q))
        else $error("current result not refreshed");
endmodule
`default_nettype wire

// >>> tb/bmal_pin_pullup.sv
/*
 * Far-side model of the shared pin: the board pull-up seen by the host.
 * Assumes the device drives the pin open-drain, low while enabled.
 */
`timescale 1ns/1ps
`default_nettype none
module bmal_pin_pullup (
    input wire logic drive_o,
    input wire logic drive_oe,
    output logic level
);
    // Released pin goes to the pull-up level, never keeps the old value
    assign level = drive_oe ? drive_o : 1'b1;
endmodule
`default_nettype wire

// >>> tb/tb_battery_measure_alert_pio.sv
/*
 * Testbench for bmal_top: byte register accesses, pin, switch, alarm.
 * Assumes the design carries its own assertions.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_battery_measure_alert_pio import bmal_pkg::*;;
    // ==========================================================
    // Stimulus and design
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic bus_lo = 1'b0;
    logic ps_n = 1'b1;
    bmal_req_s req = '0;
    logic sleep_rq = 1'b0;
    bmal_sample_s sense_s = '0;
    bmal_sample_s volt_s = '0;
    bmal_sample_s temp_s = '0;
    logic [7:0] rdata_q;
    logic [7:0] rd_v;
    logic pin_o, pin_oe, pin_i, asleep_q, dis_on_q;
    int fail_count = 0;
    int check_count = 0;

    initial forever #2 sys_clk = ~sys_clk;

    // Short periods keep the run small; the waits of 60, 520 and 25 cycles are sized to them
    bmal_top #(.CUR_CYC(200), .VOLT_CYC(20), .TEMP_CYC(500),
        .DQLOW_CYC(50), .ACC_DIV(4)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .req(req),
        .rdata_q(rdata_q), .sense_diff_voltage(sense_s),
        .volt_sample(volt_s), .temp_sample(temp_s),
        .bus_line_low(bus_lo), .sleep_req(sleep_rq),
        .power_switch_in_n(ps_n), .shared_io_pin_i(pin_i),
        .shared_io_pin_o(pin_o), .shared_io_pin_oe(pin_oe),
        .asleep_q(asleep_q), .discharge_on_q(dis_on_q));

    bmal_pin_pullup u_pullup (.drive_o(pin_o), .drive_oe(pin_oe),
        .level(pin_i));

    // ==========================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        req = '{1'b1, 1'b0, a, d};
        cyc(1);
        req = '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        cyc(1);
        req = '{1'b0, 1'b1, a, 8'h00};
        cyc(1);
        req = '0;
        cyc(1);
        rd_v = rdata_q & m;
        chk(rd_v, exp);
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        cyc(3);
        reset_n = 1'b1;
        rchk(8'h33, 8'hff, 8'h00);
        wr(8'h33, 8'h5a);
        rchk(8'h33, 8'hff, 8'h5a);
        wr(8'h33, 8'h00);
        rchk(8'h40, 8'hff, 8'h00);
        wr(8'h10, 8'h12);
        wr(8'h11, 8'h34);
        rchk(8'h10, 8'hff, 8'h12);
        rchk(8'h11, 8'hff, 8'h34);
        wr(8'h08, 8'h80);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h01);
        rchk(8'h08, 8'h40, 8'h00);
        wr(8'h08, 8'hc0);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h00);
        wr(8'h08, 8'h80);
        bus_lo = 1'b1;
        cyc(60);
        chk({7'h00, pin_oe}, 8'h00);
        rchk(8'h08, 8'h40, 8'h40);
        bus_lo = 1'b0;
        ps_n = 1'b0;
        cyc(2);
        ps_n = 1'b1;
        chk({7'h00, asleep_q}, 8'h00);
        rchk(8'h08, 8'h80, 8'h00);
        wr(8'h08, 8'hc0);
        rchk(8'h08, 8'h80, 8'h80);
        // Sleep releases a driven pin; only the power switch wakes
        wr(8'h08, 8'h80);
        sleep_rq = 1'b1;
        cyc(1);
        sleep_rq = 1'b0;
        cyc(2);
        chk({7'h00, pin_oe}, 8'h00);
        chk({6'h00, asleep_q, dis_on_q}, 8'h02);
        ps_n = 1'b0;
        cyc(1);
        ps_n = 1'b1;
        cyc(1);
        chk({6'h00, asleep_q, dis_on_q}, 8'h01);
        // Thresholds are volatile, so the host loads them first
        wr(8'h80, 8'h10);
        wr(8'h81, 8'h00);
        wr(8'h82, 8'hf0);
        wr(8'h83, 8'h00);
        wr(8'h84, 8'h7f);
        wr(8'h85, 8'h80);
        wr(8'h10, 8'h00);
        wr(8'h01, 8'h04);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h00);
        wr(8'h10, 8'h20);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h01);
        wr(8'h10, 8'h00);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h00);
        wr(8'h10, 8'h80);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h01);
        wr(8'h10, 8'h00);
        wr(8'h85, 8'h00);
        cyc(3);
        chk({7'h00, pin_oe}, 8'h01);
        // Measurements: trim 8 on samples of -8 gives a current result of -256 (ff00)
        wr(8'h85, 8'h80);
        wr(8'h84, 8'h18);
        wr(8'h33, 8'h08);
        sense_s = '{1'b1, 12'hff8};
        volt_s = '{1'b0, 12'h200};
        temp_s = '{1'b0, 12'h0c8};
        cyc(520);
        chk({7'h00, pin_oe}, 8'h01);
        rchk(8'h0e, 8'hff, 8'hff);
        rchk(8'h0f, 8'hff, 8'h00);
        rchk(8'h0c, 8'hff, 8'h40);
        rchk(8'h18, 8'hff, 8'h19);
        volt_s = '{1'b0, 12'h800};
        cyc(25);
        rchk(8'h0c, 8'hff, 8'h7f);
        rchk(8'h0d, 8'hff, 8'he0);
        wrap_up();
    end

    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
